// >>> rtl/sssm_pkg.sv
// Purpose: shared constants and types of the speed and stop monitor
// Assumes: 10 MHz clock, speeds in 1/min as signed integers
// Notes: times in a limit set are counted in monitoring steps
package sssm_pkg;
   localparam int SPD_W = 24;
   localparam int TIM_W = 16;
   localparam int NUM_SETS = 8;
   localparam int NFN = 3;
   // activation channel index per function
   localparam int FN_STOP = 0;
   localparam int FN_CAP = 1;
   localparam int FN_LVL = 2;
   // status word layout
   localparam int STAT_W = 32;
   localparam int BIT_STOP = 3;
   localparam int BIT_CAP = 4;
   localparam int BIT_LVL = 5;
   localparam int BIT_MAX = 16;
   // monitoring step timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int STEP_NS = 250_000;
   localparam int STEP_CYC = STEP_NS / CLK_PERIOD_NS;
   localparam int STEP_CW = 12;
   localparam logic [STEP_CW-1:0] STEP_LAST = STEP_CW'(STEP_CYC - 1);
   // error reaction codes
   localparam logic REACT_TORQUE = 1'b0;
   localparam logic REACT_STOP = 1'b1;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_STOP = 3'h2,
      ST_OFF = 3'h4
   } sssm_stop_t;

   typedef struct packed {
      logic ssRamp;
      logic ssTimed;
      logic signed [SPD_W-1:0] ssDecel;
      logic signed [SPD_W-1:0] ssNegTol;
      logic signed [SPD_W-1:0] ssPosTol;
      logic [TIM_W-1:0] ssDevTime;
      logic [TIM_W-1:0] ssDelay;
      logic signed [SPD_W-1:0] capUp;
      logic signed [SPD_W-1:0] capLo;
      logic [TIM_W-1:0] capTol;
      logic capReact;
      logic signed [SPD_W-1:0] lvlUp;
      logic signed [SPD_W-1:0] lvlLo;
      logic signed [SPD_W-1:0] lvlHyst;
      logic lvlAlways;
      logic signed [SPD_W-1:0] maxUp;
      logic signed [SPD_W-1:0] maxLo;
      logic [TIM_W-1:0] maxTol;
      logic maxReact;
   } sssm_lim_t;

   localparam sssm_lim_t LIM_DEF = '{
      ssRamp: 1'h1, ssTimed: 1'h1,
      ssDecel: 24'sh000001, ssNegTol: 24'sh000000, ssPosTol: 24'sh000000,
      ssDevTime: 16'h0000, ssDelay: 16'h0000,
      capUp: 24'sh01d4c0, capLo: -24'sh01d4c0, capTol: 16'h0000,
      capReact: REACT_TORQUE,
      lvlUp: 24'sh00afc8, lvlLo: -24'sh00afc8, lvlHyst: 24'sh000000,
      lvlAlways: 1'h0,
      maxUp: 24'sh01d4c0, maxLo: -24'sh01d4c0, maxTol: 16'h0000,
      maxReact: REACT_TORQUE
   };

   typedef struct packed {
      logic [NFN-1:0] syA1;
      logic [NFN-1:0] syA2;
      logic [NFN-1:0] syB1;
      logic [NFN-1:0] syB2;
      logic [STEP_CW-1:0] stepCnt;
      logic [NFN-1:0] act;
      sssm_stop_t stopSt;
      logic signed [SPD_W-1:0] rampRef;
      logic [TIM_W-1:0] ssDev;
      logic [TIM_W-1:0] ssDly;
      logic [TIM_W-1:0] capCnt;
      logic [TIM_W-1:0] maxCnt;
      logic stopErr;
      logic torqueOff;
      logic lvlOk;
      logic maxTrip;
      logic [STAT_W-1:0] status;
   } sssm_state_t;

   localparam sssm_state_t ST_RST = '{
      syA1: 3'h0, syA2: 3'h0, syB1: 3'h0, syB2: 3'h0,
      stepCnt: 12'h000, act: 3'h0, stopSt: ST_IDLE,
      rampRef: 24'sh000000, ssDev: 16'h0000, ssDly: 16'h0000,
      capCnt: 16'h0000, maxCnt: 16'h0000,
      stopErr: 1'h0, torqueOff: 1'h0, lvlOk: 1'h0, maxTrip: 1'h0,
      status: 32'h00000000
   };
endpackage

// >>> rtl/sssm_lim_mem.sv
// Purpose: storage of the selectable limit sets
// Assumes: writes and index selection come from logic on clk
// Notes: read data is registered, one cycle behind the index
`timescale 1ns/1ns
module sssm_lim_mem #(
   parameter int DEPTH = sssm_pkg::NUM_SETS,
   parameter int IW = $clog2(DEPTH)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // write side
   input wire logic we,
   input wire logic [IW-1:0] wIdx,
   input wire sssm_pkg::sssm_lim_t wData,
   // read side
   input wire logic [IW-1:0] rIdx,
   output sssm_pkg::sssm_lim_t rData
);
   typedef struct packed {
      sssm_pkg::sssm_lim_t [DEPTH-1:0] mem;
      sssm_pkg::sssm_lim_t rd;
   } sssm_mem_st_t;

   sssm_mem_st_t s_r;
   sssm_mem_st_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (we) begin
         s_nxt.mem[wIdx] = wData;
      end
      s_nxt.rd = s_r.mem[rIdx];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '{mem: {DEPTH{sssm_pkg::LIM_DEF}}, rd: sssm_pkg::LIM_DEF};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rData = s_r.rd;
endmodule // sssm_lim_mem

// >>> rtl/sssm_monitor.sv
// Purpose: speed based stop, limited speed, level output and max speed monitor
// Assumes: speed sampled from logic on clk; channel pins are asynchronous
// Notes: all supervision runs once per monitoring step of 250 us
// Functional notes
// RL1 - ramp stop supervises deceleration, torque-off at standstill
// RL2 - ramp deviation beyond window time forces torque-off
// RL3 - band from negative and positive tolerance values
// RL4 - ramp, delay or both; first wins
// RL5 - timed stop: delay expiry, no speed check
// RL6 - limited speed: upper forward, lower reverse
// RL7 - deviation counter up outside, down inside
// RL8 - tolerance exceeded runs torque-off or stop
// RL9 - eight limit sets chosen by index
// RL10 - leave only on both channels or bus
// RL11 - status bits 4, 5 and 16
// RL12 - level output with hysteresis around level
// RL13 - level: upper forward, lower reverse
// RL14 - always-active option evaluates without channel
// RL15 - max speed always active, max limits disable
// RL16 - max speed: two limits, counter, reaction
// RL17 - limited speed and level switch under 4 ms
// RL18 - max speed deactivation under 4 ms
// RL19 - stop function state in status bit 3
// RL20 - counters floor at zero, checked each step
// RL21 - torque-off held until reset or rearm
`timescale 1ns/1ns
module sssm_monitor #(
   parameter int NSETS = sssm_pkg::NUM_SETS,
   parameter int IW = $clog2(NSETS)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // two-channel activation pins, one bit per function
   input wire logic [sssm_pkg::NFN-1:0] chanA,
   input wire logic [sssm_pkg::NFN-1:0] chanB,
   input wire logic [sssm_pkg::NFN-1:0] chanUsed,
   // safe bus status commands
   input wire logic busStrobe,
   input wire logic [sssm_pkg::NFN-1:0] busDemand,
   // measured speed
   input wire logic signed [sssm_pkg::SPD_W-1:0] speed,
   // limit set configuration and selection
   input wire logic cfgWe,
   input wire logic [IW-1:0] cfgIdx,
   input wire sssm_pkg::sssm_lim_t cfgData,
   input wire logic [IW-1:0] selIdx,
   // re-arm after torque-off
   input wire logic rearm,
   // results
   output logic torqueOffReq,
   output logic safeOut,
   output logic [sssm_pkg::STAT_W-1:0] statusOut
);
   localparam int SW = sssm_pkg::SPD_W;
   localparam int TW = sssm_pkg::TIM_W;

   sssm_pkg::sssm_state_t s_r;
   sssm_pkg::sssm_state_t s_nxt;
   sssm_pkg::sssm_lim_t lim;
   logic step;
   logic [sssm_pkg::NFN-1:0] bothOn;
   logic stopDem;
   logic lvlEval;
   logic signed [SW-1:0] aSpd;
   logic signed [SW-1:0] refNxt;
   logic inBand;
   logic capOut;
   logic maxOut;
   logic offTrip;
   logic stopTrip;
   logic maxHit;

   // saturating up/down deviation counter
   function automatic logic [TW-1:0] updCnt(input logic [TW-1:0] c, input logic up);
      if (up) begin
         return (c == '1) ? c : c + 16'h0001;
      end
      return (c == '0) ? c : c - 16'h0001; // [RL20]
   endfunction

   // forward speed checks the upper limit, reverse the lower one
   function automatic logic outLim(input logic signed [SW-1:0] v,
                                   input logic signed [SW-1:0] up,
                                   input logic signed [SW-1:0] lo);
      return v[SW-1] ? (v < lo) : (v > up);
   endfunction

   // sign extension so sums of speeds cannot wrap
   function automatic logic signed [SW+1:0] sx(input logic signed [SW-1:0] v);
      return {{2{v[SW-1]}}, v};
   endfunction

   sssm_lim_mem #(
      .DEPTH(NSETS),
      .IW(IW)
   ) u_limMem (
      .clk(clk),
      .rst(rst),
      .we(cfgWe),
      .wIdx(cfgIdx),
      .wData(cfgData),
      .rIdx(selIdx), // [RL9]
      .rData(lim)
   );

   always_comb begin
      s_nxt = s_r;
      offTrip = 1'b0;
      stopTrip = 1'b0;
      maxHit = 1'b0;
      s_nxt.syA1 = chanA;
      s_nxt.syA2 = s_r.syA1;
      s_nxt.syB1 = chanB;
      s_nxt.syB2 = s_r.syB1;
      step = (s_r.stepCnt == sssm_pkg::STEP_LAST);
      s_nxt.stepCnt = step ? '0 : s_r.stepCnt + 12'h001;
      bothOn = s_r.syA2 & s_r.syB2;
      // activation acts within a few cycles, far below 4 ms
      for (int i = 0; i < sssm_pkg::NFN; i++) begin
         if ((chanUsed[i] && !bothOn[i]) || (busStrobe && busDemand[i])) begin
            s_nxt.act[i] = 1'b1; // [RL17]
         end else if ((chanUsed[i] && bothOn[i]) || (busStrobe && !busDemand[i])) begin
            s_nxt.act[i] = 1'b0; // [RL10]
         end
      end
      lvlEval = s_r.act[sssm_pkg::FN_LVL] | lim.lvlAlways; // [RL14]
      stopDem = s_r.act[sssm_pkg::FN_STOP] | s_r.stopErr;
      aSpd = speed[SW-1] ? -speed : speed;
      refNxt = (s_r.rampRef > lim.ssDecel) ? s_r.rampRef - lim.ssDecel : '0; // [RL1]
      inBand = (sx(aSpd) >= sx(refNxt) - sx(lim.ssNegTol))
               && (sx(aSpd) <= sx(refNxt) + sx(lim.ssPosTol)); // [RL3]
      capOut = outLim(speed, lim.capUp, lim.capLo); // [RL6]
      maxOut = outLim(speed, lim.maxUp, lim.maxLo); // [RL16]
      if (rearm) begin
         s_nxt.capCnt = '0;
         s_nxt.maxCnt = '0;
      end
      if (step) begin
         if (s_r.act[sssm_pkg::FN_CAP]) begin
            s_nxt.capCnt = updCnt(s_nxt.capCnt, capOut); // [RL7]
            if (s_nxt.capCnt > lim.capTol) begin
               if (lim.capReact == sssm_pkg::REACT_STOP) begin
                  stopTrip = 1'b1; // [RL8]
               end else begin
                  offTrip = 1'b1; // [RL8]
               end
            end
         end else begin
            s_nxt.capCnt = '0;
         end
         // max speed is never switched off; checked every step
         s_nxt.maxCnt = updCnt(s_nxt.maxCnt, maxOut); // [RL15] [RL18] [RL20]
         if (s_nxt.maxCnt > lim.maxTol) begin
            maxHit = 1'b1; // [RL16]
            if (lim.maxReact == sssm_pkg::REACT_STOP) begin
               stopTrip = 1'b1;
            end else begin
               offTrip = 1'b1;
            end
         end
         if (!lvlEval) begin
            s_nxt.lvlOk = 1'b0;
         end else if (!speed[SW-1]) begin
            if (sx(speed) > sx(lim.lvlUp) + sx(lim.lvlHyst)) begin
               s_nxt.lvlOk = 1'b0; // [RL12] [RL13]
            end else if (sx(speed) < sx(lim.lvlUp) - sx(lim.lvlHyst)) begin
               s_nxt.lvlOk = 1'b1; // [RL12]
            end
         end else begin
            if (sx(speed) < sx(lim.lvlLo) - sx(lim.lvlHyst)) begin
               s_nxt.lvlOk = 1'b0; // [RL13]
            end else if (sx(speed) > sx(lim.lvlLo) + sx(lim.lvlHyst)) begin
               s_nxt.lvlOk = 1'b1;
            end
         end
         unique case (s_r.stopSt)
            sssm_pkg::ST_IDLE: begin
               if (stopDem) begin
                  s_nxt.stopSt = sssm_pkg::ST_STOP;
                  s_nxt.rampRef = aSpd;
                  s_nxt.ssDev = '0;
                  s_nxt.ssDly = '0;
               end
            end
            sssm_pkg::ST_STOP: begin
               if (!stopDem) begin
                  s_nxt.stopSt = sssm_pkg::ST_IDLE;
               end else begin
                  s_nxt.rampRef = refNxt;
                  s_nxt.ssDly = updCnt(s_r.ssDly, 1'b1);
                  if (lim.ssRamp) begin
                     s_nxt.ssDev = updCnt(s_r.ssDev, !inBand); // [RL2]
                     if (s_nxt.ssDev > lim.ssDevTime) begin
                        offTrip = 1'b1; // [RL2]
                     end
                     if (aSpd == '0) begin
                        offTrip = 1'b1; // [RL1] [RL4]
                     end
                  end
                  // timed expiry ignores the speed entirely
                  if (lim.ssTimed && s_nxt.ssDly >= lim.ssDelay) begin
                     offTrip = 1'b1; // [RL4] [RL5]
                  end
               end
            end
            sssm_pkg::ST_OFF: begin
            end
         endcase
      end
      // a new trip in the rearm cycle wins over the rearm
      s_nxt.torqueOff = (s_r.torqueOff && !rearm) || offTrip; // [RL21]
      s_nxt.stopErr = (s_r.stopErr && !rearm) || stopTrip;
      s_nxt.maxTrip = (s_r.maxTrip && !rearm) || maxHit;
      if (s_nxt.torqueOff) begin
         s_nxt.stopSt = sssm_pkg::ST_OFF;
      end else if (s_r.stopSt == sssm_pkg::ST_OFF) begin
         s_nxt.stopSt = sssm_pkg::ST_IDLE;
      end
      s_nxt.status = '0;
      s_nxt.status[sssm_pkg::BIT_STOP] = (s_nxt.stopSt != sssm_pkg::ST_IDLE); // [RL19]
      s_nxt.status[sssm_pkg::BIT_CAP] = s_nxt.act[sssm_pkg::FN_CAP]; // [RL11]
      s_nxt.status[sssm_pkg::BIT_LVL] = s_nxt.lvlOk; // [RL11]
      s_nxt.status[sssm_pkg::BIT_MAX] = s_nxt.maxTrip; // [RL11]
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= sssm_pkg::ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign torqueOffReq = s_r.torqueOff;
   assign safeOut = s_r.lvlOk;
   assign statusOut = s_r.status;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_tqoHold;
      torqueOffReq && !rearm |=> torqueOffReq;
   endproperty
   a_tqoHold: assert property (p_tqoHold) else $error("torque-off dropped"); // [RL21]

   property p_standstill;
      s_r.stopSt == sssm_pkg::ST_STOP && step && stopDem && lim.ssRamp && aSpd == '0
      |=> torqueOffReq && s_r.stopSt == sssm_pkg::ST_OFF;
   endproperty
   a_standstill: assert property (p_standstill) else $error("no torque-off at rest"); // [RL1]

   property p_rampDev;
      s_r.stopSt == sssm_pkg::ST_STOP && step && stopDem && lim.ssRamp && !inBand
      && s_r.ssDev >= lim.ssDevTime && s_r.ssDev != '1 |=> torqueOffReq;
   endproperty
   a_rampDev: assert property (p_rampDev) else $error("ramp deviation missed"); // [RL2]

   property p_inBand;
      s_r.stopSt == sssm_pkg::ST_STOP && step && stopDem && lim.ssRamp && inBand
      |=> s_r.ssDev == (($past(s_r.ssDev) == '0) ? '0 : $past(s_r.ssDev) - 16'h0001);
   endproperty
   a_inBand: assert property (p_inBand) else $error("in-band count wrong"); // [RL3]

   property p_delay;
      s_r.stopSt == sssm_pkg::ST_STOP && step && stopDem && lim.ssTimed
      && s_r.ssDly >= lim.ssDelay && s_r.ssDly != '1 |=> torqueOffReq;
   endproperty
   a_delay: assert property (p_delay) else $error("delay expiry missed"); // [RL4] [RL5]

   property p_capCount;
      step && s_r.act[sssm_pkg::FN_CAP] && capOut && !rearm && s_r.capCnt != '1
      |=> s_r.capCnt == $past(s_r.capCnt) + 16'h0001;
   endproperty
   a_capCount: assert property (p_capCount) else $error("speed cap count wrong"); // [RL7]

   property p_capStop;
      step && s_r.act[sssm_pkg::FN_CAP] && capOut && !rearm && s_r.capCnt >= lim.capTol
      && s_r.capCnt != '1 && lim.capReact == sssm_pkg::REACT_STOP |=> s_r.stopErr;
   endproperty
   a_capStop: assert property (p_capStop) else $error("speed cap reaction missed"); // [RL8]

   property p_lvlHyst;
      step && lvlEval && !speed[SW-1] && sx(speed) > sx(lim.lvlUp) + sx(lim.lvlHyst)
      |=> !safeOut && !statusOut[sssm_pkg::BIT_LVL];
   endproperty
   a_lvlHyst: assert property (p_lvlHyst) else $error("level output not cleared"); // [RL12]

   property p_maxTrip;
      step && maxOut && !rearm && s_r.maxCnt >= lim.maxTol && s_r.maxCnt != '1
      && lim.maxReact == sssm_pkg::REACT_TORQUE |=> torqueOffReq && statusOut[sssm_pkg::BIT_MAX];
   endproperty
   a_maxTrip: assert property (p_maxTrip) else $error("max speed trip missed"); // [RL16]

   property p_busEnter;
      busStrobe && busDemand[sssm_pkg::FN_CAP] |=> statusOut[sssm_pkg::BIT_CAP];
   endproperty
   a_busEnter: assert property (p_busEnter) else $error("bus activation missed"); // [RL10]

   property p_pinEnter;
      (!chanA[sssm_pkg::FN_CAP] && chanUsed[sssm_pkg::FN_CAP] && !busStrobe)
      ##1 (chanUsed[sssm_pkg::FN_CAP] && !busStrobe) [*2] |=> statusOut[sssm_pkg::BIT_CAP];
   endproperty
   a_pinEnter: assert property (p_pinEnter) else $error("pin activation late"); // [RL17]
endmodule // sssm_monitor

// >>> tb/sssm_drive_model.sv
// Purpose: drive controller and activation channel model
// Assumes: commands come from the bench on clk
// Notes: speed falls by decel on each tick, never below zero
`timescale 1ns/1ns
module sssm_drive_model (
   // clock
   input wire logic clk,
   // speed commands
   input wire logic tick,
   input wire logic load,
   input wire logic signed [sssm_pkg::SPD_W-1:0] loadVal,
   input wire logic signed [sssm_pkg::SPD_W-1:0] decel,
   // channel commands
   input wire logic [sssm_pkg::NFN-1:0] energise,
   input wire logic [sssm_pkg::NFN-1:0] dropB,
   // drive side
   output logic signed [sssm_pkg::SPD_W-1:0] speed,
   output logic [sssm_pkg::NFN-1:0] chanA,
   output logic [sssm_pkg::NFN-1:0] chanB
);
   initial speed = '0;
   always @(posedge clk) begin
      if (load) begin
         speed <= loadVal;
      end else if (tick && decel != '0) begin
         speed <= (speed > decel) ? speed - decel : '0;
      end
   end
   // both channels follow the command, one can be dropped on purpose
   assign chanA = energise;
   assign chanB = energise & ~dropB;
endmodule // sssm_drive_model

// >>> tb/sssm_monitor_tb.sv
// Purpose: self-checking bench of the speed and stop monitor
// Assumes: inputs change on the falling edge, one step is 2500 cycles
// Notes: checks that follow mid() are made mid-way between monitoring steps
`timescale 1ns/1ns
module sssm_monitor_tb;
   logic clk, rst, busStrobe, cfgWe, rearm, tick, load;
   logic [2:0] chanUsed, busDemand, cfgIdx, selIdx, energise, dropB, chanA, chanB;
   logic signed [sssm_pkg::SPD_W-1:0] loadVal, decel, speed;
   sssm_pkg::sssm_lim_t lim;
   logic torqueOffReq, safeOut;
   logic [31:0] statusOut;
   int ph, fails, cmp_count;

   sssm_drive_model PART (.clk(clk), .tick(tick), .load(load), .loadVal(loadVal),
      .decel(decel), .energise(energise), .dropB(dropB), .speed(speed), .chanA(chanA),
      .chanB(chanB));
   sssm_monitor DUT (.clk(clk), .rst(rst), .chanA(chanA), .chanB(chanB),
      .chanUsed(chanUsed), .busStrobe(busStrobe), .busDemand(busDemand), .speed(speed),
      .cfgWe(cfgWe), .cfgIdx(cfgIdx), .cfgData(lim), .selIdx(selIdx), .rearm(rearm),
      .torqueOffReq(torqueOffReq), .safeOut(safeOut), .statusOut(statusOut));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // phase inside the step period, used to stay clear of step edges
   always @(posedge clk) ph <= (rst || ph == 2499) ? 0 : ph + 1;
   always @(negedge clk) tick <= (ph == 1250);

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // crosses exactly n monitoring steps, then stops mid-way in the next period
   task automatic mid(input int n);
      repeat (n) begin
         do @(negedge clk); while (ph != 0);
         do @(negedge clk); while (ph != 1300);
      end
   endtask
   task automatic spd(input logic signed [23:0] v, input logic signed [23:0] d);
      load = 1'b1;
      loadVal = v;
      decel = d;
      cyc(1);
      load = 1'b0;
   endtask
   task automatic bus(input logic [2:0] d);
      busStrobe = 1'b1;
      busDemand = d;
      cyc(1);
      busStrobe = 1'b0;
      cyc(1);
   endtask
   task automatic cfg(input logic [2:0] idx);
      cfgWe = 1'b1;
      cfgIdx = idx;
      selIdx = idx;
      cyc(1);
      cfgWe = 1'b0;
      cyc(1);
   endtask
   task automatic clr;
      bus(3'h0);
      spd(24'sh000000, 24'sh000000);
      rearm = 1'b1;
      cyc(1);
      rearm = 1'b0;
      cyc(1);
      chk("rearmOff", 32'h0, torqueOffReq);
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic t_reset;
      chk("rstStatus", 32'h0, statusOut);
      chk("rstOff", 32'h0, torqueOffReq);
      chk("rstSafe", 32'h0, safeOut);
   endtask
   task automatic t_bus;
      bus(3'h2);
      chk("busOn", 32'h1, statusOut[4]);
      bus(3'h0);
      chk("busOff", 32'h0, statusOut[4]);
   endtask
   task automatic t_pins;
      chanUsed = 3'h2;
      cyc(4);
      chk("pinsIdle", 32'h0, statusOut[4]);
      dropB = 3'h2;
      cyc(4);
      chk("pinOneLow", 32'h1, statusOut[4]);
      bus(3'h0);
      chk("busRefused", 32'h1, statusOut[4]);
      dropB = 3'h0;
      cyc(4);
      chk("pinsBoth", 32'h0, statusOut[4]);
      chanUsed = 3'h0;
   endtask
   task automatic t_level;
      lim = sssm_pkg::LIM_DEF;
      lim.lvlUp = 24'sh0003e8;
      lim.lvlLo = -24'sh0003e8;
      lim.lvlHyst = 24'sh000064;
      lim.lvlAlways = 1'b1;
      cfg(3'h2);
      spd(24'sh0001f4, 24'sh000000);
      mid(1);
      chk("lvlAlways", 32'h1, safeOut);
      chk("lvlBit", 32'h1, statusOut[5]);
      spd(24'sh00041a, 24'sh000000);
      mid(1);
      chk("lvlHoldHi", 32'h1, safeOut);
      spd(24'sh0004b0, 24'sh000000);
      mid(1);
      chk("lvlOver", 32'h0, safeOut);
      spd(24'sh00041a, 24'sh000000);
      mid(1);
      chk("lvlHoldLo", 32'h0, safeOut);
      spd(24'sh000352, 24'sh000000);
      mid(1);
      chk("lvlBack", 32'h1, safeOut);
      spd(-24'sh0004b0, 24'sh000000);
      mid(1);
      chk("lvlRevOver", 32'h0, safeOut);
      spd(-24'sh000352, 24'sh000000);
      mid(1);
      chk("lvlRevBack", 32'h1, safeOut);
      lim.lvlAlways = 1'b0;
      cfg(3'h2);
      mid(1);
      chk("lvlNoAct", 32'h0, safeOut);
   endtask
   task automatic t_max;
      lim = sssm_pkg::LIM_DEF;
      lim.maxUp = 24'sh0007d0;
      lim.maxLo = -24'sh0007d0;
      lim.maxTol = 16'h0002;
      cfg(3'h3);
      selIdx = 3'h0;
      spd(24'sh0009c4, 24'sh000000);
      mid(1);
      chk("maxDefSet", 32'h0, torqueOffReq);
      selIdx = 3'h3;
      mid(2);
      chk("maxTol", 32'h0, torqueOffReq);
      spd(24'sh0005dc, 24'sh000000);
      mid(1);
      spd(24'sh0009c4, 24'sh000000);
      mid(1);
      chk("maxDown", 32'h0, torqueOffReq);
      mid(1);
      chk("maxTrip", 32'h1, torqueOffReq);
      chk("maxBit", 32'h1, statusOut[16]);
      spd(24'sh0005dc, 24'sh000000);
      mid(1);
      chk("maxLatch", 32'h1, torqueOffReq);
      clr();
      chk("maxBitClr", 32'h0, statusOut[16]);
   endtask
   task automatic t_cap;
      lim = sssm_pkg::LIM_DEF;
      lim.capUp = 24'sh000bb8;
      lim.capLo = -24'sh000bb8;
      lim.capReact = sssm_pkg::REACT_STOP;
      lim.ssRamp = 1'b0;
      lim.ssDelay = 16'h0008;
      cfg(3'h4);
      bus(3'h2);
      spd(-24'sh000dac, 24'sh000000);
      mid(2);
      chk("capStop", 32'h1, statusOut[3]);
      chk("capNoOff", 32'h0, torqueOffReq);
      clr();
      mid(1);
      chk("stopIdle", 32'h0, statusOut[3]);
   endtask
   // runs a stop in one limit set and checks torque-off timing
   task automatic t_stop(input logic [2:0] idx, input logic signed [23:0] dec, input int a,
                         input int b);
      cfg(idx);
      spd(24'sh00012c, dec);
      bus(3'h1);
      mid(1);
      chk("stopBit", 32'h1, statusOut[3]);
      mid(a);
      chk("stopEarly", 32'h0, torqueOffReq);
      mid(b);
      chk("stopOff", 32'h1, torqueOffReq);
      clr();
   endtask
   task automatic t_stops;
      lim = sssm_pkg::LIM_DEF;
      lim.ssRamp = 1'b0;
      lim.ssDelay = 16'h0003;
      t_stop(3'h5, 24'sh000000, 2, 1);
      lim.ssRamp = 1'b1;
      lim.ssDelay = 16'h000a;
      lim.ssDecel = 24'sh000064;
      lim.ssNegTol = 24'sh000032;
      lim.ssPosTol = 24'sh000032;
      t_stop(3'h6, 24'sh000078, 2, 1);
      lim.ssTimed = 1'b0;
      lim.ssDevTime = 16'h0001;
      t_stop(3'h7, 24'sh000000, 1, 1);
      lim.ssTimed = 1'b1;
      lim.ssDelay = 16'h0001;
      lim.ssDevTime = 16'h0005;
      t_stop(3'h1, 24'sh000000, 0, 1);
   endtask

   initial begin
      {rst, busStrobe, cfgWe, rearm, load} = 5'h10;
      {chanUsed, busDemand, cfgIdx, selIdx, dropB} = 15'h0000;
      energise = 3'h7;
      loadVal = '0;
      decel = '0;
      lim = sssm_pkg::LIM_DEF;
      fails = 0;
      cmp_count = 0;
      cyc(8);
      rst = 1'b0;
      cyc(1);
      t_reset();
      t_bus();
      t_pins();
      t_level();
      t_max();
      t_cap();
      t_stops();
      finish_test();
   end
   initial begin
      #(40 * 2500 * 100);
      fails++;
      finish_test();
   end
endmodule // sssm_monitor_tb
